/* File: rtl/dpc_pkg.sv */
// package: shared constants and frame types of the periodic command decoder
package dpc_pkg;

    // register bus widths and offsets
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned DATA_W          = 8;
    localparam logic [7:0]  OFS_NODE_ADDR   = 8'h00;
    localparam logic [7:0]  OFS_LOCK_CTRL   = 8'h01;
    localparam logic [7:0]  OFS_DIAG_CFG    = 8'h02;
    localparam logic [7:0]  OFS_STATUS      = 8'h03;

    // field positions
    localparam int unsigned LOCK_BIT_POS    = 0;
    localparam int unsigned DIAG_EN_POS     = 0;
    localparam int unsigned DIAG_FRAG_POS   = 1;

    // values after reset
    localparam logic [3:0]  NODE_ADDR_RST   = 4'h0;
    localparam logic        LOCK_RST        = 1'b0;
    localparam logic        DIAG_EN_RST     = 1'b0;
    localparam logic        DIAG_FRAG_RST   = 1'b0;

    // command lengths in bits and fragment sizes
    localparam logic [5:0]  LEN_BCAST       = 6'h01;
    localparam logic [5:0]  LEN_FRAG_SMALL  = 6'h02;
    localparam logic [5:0]  LEN_FRAG_LARGE  = 6'h04;
    localparam logic [5:0]  LEN_FULL        = 6'h20;
    localparam logic [5:0]  CNT_RST         = 6'h00;

    // special addresses and command codes
    localparam logic [3:0]  ADDR_GLOBAL     = 4'h0;
    localparam logic [3:0]  CODE_READ       = 4'h0;
    localparam logic [3:0]  CODE_WRITE      = 4'h8;
    localparam logic [3:0]  CODE_ENTER_PER  = 4'hb;
    localparam logic [15:0] RESV_DATA       = 16'h0000;

    // check sum generator, plain defaults
    localparam logic [7:0]  CRC_POLY        = 8'h1d;
    localparam logic [7:0]  CRC_SEED        = 8'hff;

    // one 32-bit command or answer frame, most significant field first
    typedef struct packed {
        logic [3:0]  addr;
        logic [3:0]  code;
        logic [15:0] data;
        logic [7:0]  crc;
    } dpc_frame_s;

    // one received command as delivered by the bit decoder
    typedef struct packed {
        logic [5:0]  len;
        logic [31:0] bits;
    } dpc_rx_s;

endpackage

/* File: rtl/dpc_decode.sv */
// module: reserved command answers and periodic / background command decode
//
// Contract
// - answer reserved code on own address, good CRC
// - answer echoes address, code, correct CRC
// - reserved code for other address ignored
// - lock bit set enables periodic mode
// - periodic mode decodes broadcast reads, fragments
// - same bit encoding in all modes
// - same message format in all modes
// - no diagnostics: respond only to one bit
// - broadcast read is one bit, either value
// - fragments of 2 or 4 bits per size bit
// - diagnostics: respond to broadcast or fragment only
// - broadcast or any length but 2 or 4 clears assembly
// - diagnostic answer after full valid 32 bits
// - assembled command checked like normal command
// - broadcast reads get no error check
// - lock bit stays set until reset
// - mode table from lock and enable bit
`timescale 1ns/100ps
module dpc_decode
(
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     arst_n_i,
    // register port
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [7:0]               reg_rdata_o,
    // received commands from the bit decoder
    input  wire logic                     rx_valid_i,
    input  wire dpc_pkg::dpc_rx_s         rx_i,
    // answers
    output logic                          per_resp_o,
    output logic                          resv_resp_valid_o,
    output dpc_pkg::dpc_frame_s           resv_resp_o,
    output logic                          diag_cmd_valid_o,
    output dpc_pkg::dpc_frame_s           diag_cmd_o
);

    ////////////////////////////////////////////////////////////////////////////
    // check sum over the 24 leading bits, most significant first
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = dpc_pkg::CRC_SEED;
        for (int i = 23; i >= 0; i--)
        begin
            if (c[7] ^ d[i])
                c = {c[6:0], 1'b0} ^ dpc_pkg::CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // reserved codes are all but read, write and enter periodic
    function automatic logic is_reserved(input logic [3:0] code);
        return (code != dpc_pkg::CODE_READ) && (code != dpc_pkg::CODE_WRITE)
            && (code != dpc_pkg::CODE_ENTER_PER);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // configuration state
    logic [3:0] node_addr;
    logic       lock;
    logic       diag_en;
    logic       diag_frag;
    logic [5:0] frag_cnt;
    logic [31:0] frag_word;

    // decode of the current command
    logic        per_on;
    logic        diag_on;
    logic [5:0]  frag_len;
    logic        is_bcast;
    logic        is_frag;
    logic        is_full;
    logic        other_frag;
    dpc_pkg::dpc_frame_s rx_frame;
    dpc_pkg::dpc_frame_s next_diag;
    logic [5:0]  next_cnt;
    logic        asm_done;
    logic        rx_crc_ok;
    logic        asm_crc_ok;
    logic        asm_addr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // node address register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            node_addr <= dpc_pkg::NODE_ADDR_RST;
        else if (reg_wr_i && reg_addr_i == dpc_pkg::OFS_NODE_ADDR)
            node_addr <= reg_wdata_i[3:0];
    end

    // lock control: write one sets, nothing but reset clears
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            lock <= dpc_pkg::LOCK_RST;
        else if (reg_wr_i && reg_addr_i == dpc_pkg::OFS_LOCK_CTRL
                 && reg_wdata_i[dpc_pkg::LOCK_BIT_POS])
            lock <= 1'b1;
    end

    // diagnostic configuration register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            diag_en   <= dpc_pkg::DIAG_EN_RST;
            diag_frag <= dpc_pkg::DIAG_FRAG_RST;
        end
        else if (reg_wr_i && reg_addr_i == dpc_pkg::OFS_DIAG_CFG)
        begin
            diag_en   <= reg_wdata_i[dpc_pkg::DIAG_EN_POS];
            diag_frag <= reg_wdata_i[dpc_pkg::DIAG_FRAG_POS];
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            reg_rdata_o <= 8'h00;
        else if (!reg_rd_i)
            reg_rdata_o <= 8'h00;
        else
        begin
            case (reg_addr_i)
                dpc_pkg::OFS_NODE_ADDR: reg_rdata_o <= {4'h0, node_addr};
                dpc_pkg::OFS_LOCK_CTRL: reg_rdata_o <= {7'h00, lock};
                dpc_pkg::OFS_DIAG_CFG:  reg_rdata_o <= {6'h00, diag_frag, diag_en};
                dpc_pkg::OFS_STATUS:    reg_rdata_o <= {frag_cnt, diag_on, per_on};
                default:                reg_rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode selection and length classes
    assign per_on     = lock;
    assign diag_on    = lock & diag_en;
    assign frag_len   = diag_frag ? dpc_pkg::LEN_FRAG_LARGE : dpc_pkg::LEN_FRAG_SMALL;
    assign is_bcast   = rx_i.len == dpc_pkg::LEN_BCAST;
    assign is_frag    = diag_on && rx_i.len == frag_len;
    assign is_full    = rx_i.len == dpc_pkg::LEN_FULL;
    assign other_frag = diag_on && !is_frag
                        && (rx_i.len == dpc_pkg::LEN_FRAG_SMALL || rx_i.len == dpc_pkg::LEN_FRAG_LARGE);
    // same word layout in every mode
    assign rx_frame   = rx_i.bits;
    assign rx_crc_ok  = crc8(rx_frame[31:8]) == rx_frame.crc;

    // assembly arithmetic: fragments enter at the low end
    assign next_cnt    = frag_cnt + frag_len;
    assign next_diag   = diag_frag ? {frag_word[27:0], rx_i.bits[3:0]}
                                   : {frag_word[29:0], rx_i.bits[1:0]};
    assign asm_done    = is_frag && next_cnt == dpc_pkg::LEN_FULL;
    assign asm_crc_ok  = crc8(next_diag[31:8]) == next_diag.crc;
    assign asm_addr_ok = next_diag.addr == node_addr || next_diag.addr == dpc_pkg::ADDR_GLOBAL;

    ////////////////////////////////////////////////////////////////////////////
    // background command assembly
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            frag_cnt  <= dpc_pkg::CNT_RST;
            frag_word <= 32'h00000000;
        end
        else if (!diag_on)
        begin
            frag_cnt  <= dpc_pkg::CNT_RST;
            frag_word <= 32'h00000000;
        end
        else if (rx_valid_i)
        begin
            if (asm_done)
            begin
                frag_cnt  <= dpc_pkg::CNT_RST;
                frag_word <= 32'h00000000;
            end
            else if (is_frag)
            begin
                frag_cnt  <= next_cnt;
                frag_word <= next_diag;
            end
            else if (!other_frag)
            begin
                frag_cnt  <= dpc_pkg::CNT_RST;
                frag_word <= 32'h00000000;
            end
        end
    end

    // periodic answer request
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            per_resp_o <= 1'b0;
        else
            per_resp_o <= rx_valid_i && per_on && (is_bcast || is_frag);
    end

    // completed diagnostic command handed on split into fields
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            diag_cmd_valid_o <= 1'b0;
            diag_cmd_o       <= '0;
        end
        else
        begin
            diag_cmd_valid_o <= rx_valid_i && asm_done && asm_crc_ok && asm_addr_ok;
            if (rx_valid_i && asm_done)
                diag_cmd_o <= next_diag;
        end
    end

    // reserved command answer in command and response mode
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            resv_resp_valid_o <= 1'b0;
            resv_resp_o       <= '0;
        end
        else
        begin
            resv_resp_valid_o <= rx_valid_i && !per_on && is_full && is_reserved(rx_frame.code)
                                 && rx_frame.addr == node_addr && rx_crc_ok;
            if (rx_valid_i && is_full)
            begin
                resv_resp_o.addr <= rx_frame.addr;
                resv_resp_o.code <= rx_frame.code;
                resv_resp_o.data <= dpc_pkg::RESV_DATA;
                resv_resp_o.crc  <= crc8({rx_frame.addr, rx_frame.code, dpc_pkg::RESV_DATA});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_bcast_in;
        rx_valid_i && per_on && is_bcast;
    endsequence

    sequence s_resv_in;
        rx_valid_i && !per_on && is_full && is_reserved(rx_frame.code)
        && rx_frame.addr == node_addr && rx_crc_ok;
    endsequence

    property p_lock_sticky;
        lock |=> lock[*8];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit dropped");

    property p_resv_answer;
        s_resv_in |=> resv_resp_valid_o && resv_resp_o.addr == $past(rx_frame.addr)
                      && resv_resp_o.code == $past(rx_frame.code);
    endproperty
    a_resv_answer: assert property (p_resv_answer) else $error("reserved command unanswered");

    property p_resv_crc;
        resv_resp_valid_o |-> resv_resp_o.crc == crc8(resv_resp_o[31:8]);
    endproperty
    a_resv_crc: assert property (p_resv_crc) else $error("reserved answer check sum wrong");

    property p_resv_ignore;
        rx_valid_i && rx_frame.addr != node_addr |=> !resv_resp_valid_o;
    endproperty
    a_resv_ignore: assert property (p_resv_ignore) else $error("foreign reserved command answered");

    property p_bcast;
        s_bcast_in |=> per_resp_o;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast read unanswered");

    property p_no_resp;
        rx_valid_i && !(per_on && (is_bcast || is_frag)) |=> !per_resp_o;
    endproperty
    a_no_resp: assert property (p_no_resp) else $error("periodic answer to wrong length");

    property p_clear;
        s_bcast_in ##0 diag_on |=> frag_cnt == dpc_pkg::CNT_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("assembly not cleared");

    property p_diag_full;
        diag_cmd_valid_o |-> $past(frag_cnt) + $past(frag_len) == dpc_pkg::LEN_FULL && $past(diag_on);
    endproperty
    a_diag_full: assert property (p_diag_full) else $error("diagnostic command not complete");

    property p_diag_split;
        diag_cmd_valid_o |-> diag_cmd_o.crc == crc8({diag_cmd_o.addr, diag_cmd_o.code, diag_cmd_o.data});
    endproperty
    a_diag_split: assert property (p_diag_split) else $error("bad diagnostic command passed");

    property p_off;
        !per_on && rx_valid_i |=> !per_resp_o;
    endproperty
    a_off: assert property (p_off) else $error("periodic answer while mode off");

endmodule

/* File: sim/dpc_master.sv */
// partner model: bit decoder handing received commands to the block
`timescale 1ns/100ps
module dpc_master
(
    // clock
    input  wire logic        clk_i,
    // received command
    output logic             rx_valid_o,
    output dpc_pkg::dpc_rx_s rx_o
);
    // quiet at start
    initial
    begin
        rx_valid_o = 1'b0;
        rx_o       = '0;
    end
    // one command for one cycle, payload inverted afterwards so stale bits never match
    task automatic send(input logic [5:0] len, input logic [31:0] bits);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_o       <= '{len: len, bits: bits};
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_o       <= ~rx_o;
    endtask
endmodule

/* File: sim/dpc_decode_bench.sv */
// testbench: periodic command decoder against a reference model
`timescale 1ns/100ps
module dpc_decode_bench;
    logic                clk_i       = 1'b0;
    logic                arst_n_i    = 1'b0;
    logic [7:0]          reg_addr_i  = 8'h00;
    logic [7:0]          reg_wdata_i = 8'h00;
    logic                reg_wr_i    = 1'b0;
    logic                reg_rd_i    = 1'b0;
    logic [7:0]          reg_rdata_o;
    logic                rx_valid_i;
    dpc_pkg::dpc_rx_s    rx_i;
    logic                per_resp_o;
    logic                resv_resp_valid_o;
    logic                diag_cmd_valid_o;
    dpc_pkg::dpc_frame_s resv_resp_o;
    dpc_pkg::dpc_frame_s diag_cmd_o;
    int                  n_fail = 0;
    int                  samples_checked = 0;
    integer              seed = 87;
    // reference model state
    logic [3:0]          m_node = 4'h0;
    logic                m_lock = 1'b0;
    logic                m_en   = 1'b0;
    logic                m_big  = 1'b0;
    logic [31:0]         m_asm  = '0;
    int                  m_cnt  = 0;

    ////////////////////////////////////////////////////////////////
    // clock, partner and device
    always #12.5 clk_i = ~clk_i;
    dpc_master u_dpc_master (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_o(rx_i));
    dpc_decode u_dpc_decode (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .rx_valid_i(rx_valid_i), .rx_i(rx_i), .per_resp_o(per_resp_o), .resv_resp_valid_o(resv_resp_valid_o),
        .resv_resp_o(resv_resp_o), .diag_cmd_valid_o(diag_cmd_valid_o), .diag_cmd_o(diag_cmd_o));

    ////////////////////////////////////////////////////////////////
    // compare, verdict, check sum and frame helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = dpc_pkg::CRC_SEED;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? dpc_pkg::CRC_POLY : 8'h00);
        return c;
    endfunction
    function automatic logic [31:0] mkf(input logic [3:0] a, input logic [3:0] c, input logic [15:0] d);
        return {a, c, d, crc8({a, c, d})};
    endfunction

    ////////////////////////////////////////////////////////////////
    // register port, model follows every write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
        if (a == 8'h00)
            m_node = d[3:0];
        if (a == 8'h01 && d[0])
            m_lock = 1'b1;
        if (a == 8'h02)
        begin
            m_en  = d[0];
            m_big = d[1];
            if (!d[0])
                m_cnt = 0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        check(reg_rdata_o, exp);
        @(posedge clk_i);
        #1;
        check(reg_rdata_o, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////
    // one command through the partner, expectations from the model
    task automatic cmd(input logic [5:0] len, input logic [31:0] bits);
        logic       ep;
        logic       er;
        logic       ed;
        logic [5:0] fl;
        fl = m_big ? 6'h04 : 6'h02;
        ep = m_lock && (len == 6'h01 || (m_en && len == fl));
        er = !m_lock && len == 6'h20 && bits[31:28] == m_node && bits[7:0] == crc8(bits[31:8])
             && !(bits[27:24] == 4'h0 || bits[27:24] == 4'h8 || bits[27:24] == 4'hb);
        ed = 1'b0;
        if (m_lock && m_en && len == fl)
        begin
            m_asm = (m_asm << len) | bits;
            m_cnt += len;
        end
        else if (len != 6'h02 && len != 6'h04)
            m_cnt = 0;
        if (m_cnt == 32)
        begin
            ed    = m_asm[7:0] == crc8(m_asm[31:8]) && (m_asm[31:28] == m_node || m_asm[31:28] == 4'h0);
            m_cnt = 0;
        end
        u_dpc_master.send(len, bits);
        #1;
        check(per_resp_o, ep);
        check(resv_resp_valid_o, er);
        check(diag_cmd_valid_o, ed);
        if (er)
            check(resv_resp_o, {bits[31:24], 16'h0000, crc8({bits[31:24], 16'h0000})});
        if (ed)
            check(diag_cmd_o, m_asm);
    endtask
    // fragments of a word in the selected size, starting at fragment first
    task automatic frags(input logic [31:0] w, input int first, input int n);
        logic [31:0] t;
        logic [5:0]  sz;
        sz = m_big ? 6'h04 : 6'h02;
        t  = w << (sz * first);
        repeat (n)
        begin
            cmd(sz, t >> (32 - sz));
            t = t << sz;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        repeat (100000) @(posedge clk_i);
        n_fail++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        logic [31:0] w;
        int          n;
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int a = 0; a < 5; a++)
            rd(a[7:0], 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h00);
        wr(8'h00, 8'h05);
        rd(8'h00, 8'h05);
        // every code: own address, other address, broken check sum
        for (int c = 0; c < 16; c++)
        begin
            w = mkf(4'h5, c[3:0], 16'($random(seed)));
            cmd(6'h20, w);
            cmd(6'h20, mkf(4'h6, c[3:0], w[23:8]));
            cmd(6'h20, w ^ 32'h1);
        end
        cmd(6'h01, 32'h1);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00);
        wr(8'h01, 8'h01);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h01);
        rd(8'h03, 8'h01);
        // diagnostics off: lengths 0 to 33, only one bit answers
        w = mkf(4'h5, 4'h1, 16'h0000);
        for (int l = 0; l < 34; l++)
            cmd(l[5:0], w >> (32 - l));
        cmd(6'h01, 32'h0);
        for (int s = 0; s < 2; s++)
        begin
            wr(8'h02, {6'h00, s[0], 1'b1});
            rd(8'h03, 8'h03);
            n = s ? 8 : 16;
            w = mkf(4'h5, 4'h0, 16'($random(seed)));
            frags(w, 0, 3);
            cmd(6'h01, 32'(s));
            frags(w, 0, 1);
            cmd(s ? 6'h02 : 6'h04, 32'h3);
            frags(w, 1, n - 1);
            frags(w, 0, 2);
            cmd(6'h03, 32'h5);
            frags(w, 0, n);
            frags(mkf(4'h0, 4'h8, 16'($random(seed))), 0, n);
            frags(w ^ 32'h1, 0, n);
            frags(mkf(4'h9, 4'h0, 16'h1234), 0, n);
            frags(w, 0, 2);
            wr(8'h02, {6'h00, s[0], 1'b0});
            wr(8'h02, {6'h00, s[0], 1'b1});
            frags(w, 0, n);
        end
        // reset in mid-run drops the lock
        frags(w, 0, 3);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        m_node = 4'h0;
        m_lock = 1'b0;
        m_en   = 1'b0;
        m_big  = 1'b0;
        m_cnt  = 0;
        rd(8'h01, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h00, 8'h00);
        cmd(6'h01, 32'h0);
        give_verdict();
    end
endmodule
